// ---- logic/isrp_slave.sv ----
// Purpose: i2c slave giving a host access to internal registers and FIFO
// Assumes: linkClk oversamples SCL/SDA; regRdData valid in regRdStb cycle
// Notes: never stretches SCL; read data must return within SCL high time
`timescale 1ns/10ps

module isrp_slave #(
  parameter logic [7:0] FIFO_ADDR = 8'h05
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic linkClk,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire isrp_pkg::isrp_cfg_s cfgIn,
  output logic [7:0] regAddr,
  output logic [7:0] regWrData,
  output logic regWrStb,
  output logic regRdStb,
  input wire logic [7:0] regRdData,
  output logic busBusy
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // FIFO address stays put, any other register advances
  function automatic logic [7:0] advance(input logic [7:0] a);
    advance = (a == FIFO_ADDR) ? a : a + 8'h01;
  endfunction

  // ----------------------------------------------------------------
  // link domain reset and input synchronisers
  // ----------------------------------------------------------------
  logic [1:0] linkRst_q;
  logic linkRstn;
  logic [1:0] pinSync1_q;
  logic [1:0] pinSync2_q;
  isrp_pkg::isrp_cfg_s cfgSync1_q;
  isrp_pkg::isrp_cfg_s cfgSync2_q;

  assign linkRstn = linkRst_q[1];

  // reset release synchronised to the link clock
  always_ff @(posedge linkClk or negedge rstn)
  begin
    if (!rstn)
      linkRst_q <= 2'h0;
    else
      linkRst_q <= {linkRst_q[0], 1'b1};
  end

  // two flops on every pin and strap, bit 1 is SCL
  always_ff @(posedge linkClk or negedge linkRstn)
  begin
    if (!linkRstn)
    begin
      pinSync1_q <= isrp_pkg::LINE_IDLE;
      pinSync2_q <= isrp_pkg::LINE_IDLE;
      cfgSync1_q <= isrp_pkg::CFG_RST;
      cfgSync2_q <= isrp_pkg::CFG_RST;
    end
    else
    begin
      pinSync1_q <= {sclIn, sdaIn};
      pinSync2_q <= pinSync1_q;
      cfgSync1_q <= cfgIn;
      cfgSync2_q <= cfgSync1_q;
    end
  end

  // ----------------------------------------------------------------
  // spike filter and bus conditions
  // ----------------------------------------------------------------
  logic [1:0] filt_q;
  logic [1:0] filtPrev_q;
  logic [2:0] fcnt_q [2];
  logic sclF;
  logic sdaF;
  logic sclP;
  logic sdaP;
  logic sclRise;
  logic sclFall;
  logic startEv;
  logic stopEv;

  // a level is taken only after it held for the whole spike time
  always_ff @(posedge linkClk or negedge linkRstn)
  begin
    if (!linkRstn)
    begin
      filt_q <= isrp_pkg::LINE_IDLE;
      filtPrev_q <= isrp_pkg::LINE_IDLE;
      for (int i = 0; i < 2; i++)
        fcnt_q[i] <= isrp_pkg::FILT_RST;
    end
    else
    begin
      filtPrev_q <= filt_q;
      for (int i = 0; i < 2; i++)
      begin
        if (pinSync2_q[i] == filt_q[i])
          fcnt_q[i] <= isrp_pkg::FILT_RST;
        else if (fcnt_q[i] == isrp_pkg::FILT_LAST)
        begin
          filt_q[i] <= pinSync2_q[i];
          fcnt_q[i] <= isrp_pkg::FILT_RST;
        end
        else
          fcnt_q[i] <= fcnt_q[i] + 3'h1;
      end
    end
  end

  // edges and START / STOP on filtered lines
  assign sclF = filt_q[1];
  assign sdaF = filt_q[0];
  assign sclP = filtPrev_q[1];
  assign sdaP = filtPrev_q[0];
  assign sclRise = sclF & ~sclP;
  assign sclFall = ~sclF & sclP;
  assign startEv = sclF & sclP & sdaP & ~sdaF;
  assign stopEv = sclF & sclP & ~sdaP & sdaF;

  // ----------------------------------------------------------------
  // own address
  // ----------------------------------------------------------------
  logic [1:0] lowBits;
  logic [6:0] myAddr;

  // pin source on the point-to-point variant forces the upper bit low
  assign lowBits = cfgSync2_q.fromNv ? cfgSync2_q.nvBits :
                   {cfgSync2_q.pinBits[1] & ~cfgSync2_q.p2p,
                    cfgSync2_q.pinBits[0]};
  assign myAddr = {isrp_pkg::ADDR_UPPER, lowBits};

  // ----------------------------------------------------------------
  // link state machine
  // ----------------------------------------------------------------
  isrp_pkg::isrp_state_e state_q;
  isrp_pkg::isrp_state_e state_d;
  logic [3:0] bitCnt_q;
  logic [3:0] bitCnt_d;
  logic [7:0] shift_q;
  logic [7:0] shift_d;
  logic [7:0] ptr_q;
  logic [7:0] ptr_d;
  logic drive_q;
  logic drive_d;
  logic sdaBit_q;
  logic sdaBit_d;
  logic rwRead_q;
  logic rwRead_d;
  logic busy_q;
  logic busy_d;
  isrp_pkg::isrp_req_s req_q;
  isrp_pkg::isrp_req_s req_d;
  logic reqTgl_q;
  logic reqTgl_d;
  logic [7:0] rdBuf_q;
  logic rxState;
  logic shiftIn;
  logic countBit;
  logic byteDone;
  logic addrMatch;

  // receive shifting and bit counting, MSB first
  assign rxState = (state_q == isrp_pkg::ST_ADDR) |
                   (state_q == isrp_pkg::ST_REG) |
                   (state_q == isrp_pkg::ST_WDATA);
  assign shiftIn = sclRise & rxState;
  assign countBit = sclRise & (rxState | (state_q == isrp_pkg::ST_RDATA));
  assign byteDone = sclFall & (bitCnt_q == isrp_pkg::BIT_LAST);
  assign addrMatch = (shift_q[7:1] == myAddr);

  // next state of the link side
  always_comb
  begin
    state_d = state_q;
    bitCnt_d = bitCnt_q;
    shift_d = shiftIn ? {shift_q[6:0], sdaF} : shift_q;
    ptr_d = ptr_q;
    drive_d = drive_q;
    sdaBit_d = sdaBit_q;
    rwRead_d = rwRead_q;
    busy_d = busy_q;
    req_d = req_q;
    reqTgl_d = reqTgl_q;
    if (countBit)
      bitCnt_d = bitCnt_q + 4'h1;
    if (startEv)
    begin
      // restart address reception, START or repeated START alike
      state_d = isrp_pkg::ST_ADDR;
      bitCnt_d = isrp_pkg::BIT_RST;
      drive_d = 1'b0;
      busy_d = 1'b1;
    end
    else if (stopEv)
    begin
      state_d = isrp_pkg::ST_IDLE;
      drive_d = 1'b0;
      busy_d = 1'b0;
    end
    else
    begin
      unique case (state_q)
        isrp_pkg::ST_IDLE, isrp_pkg::ST_IGNORE:
          drive_d = 1'b0;
        isrp_pkg::ST_ADDR:
          if (byteDone)
          begin
            if (addrMatch)
            begin
              state_d = isrp_pkg::ST_ADDR_ACK;
              rwRead_d = shift_q[0];
              drive_d = 1'b1;
              sdaBit_d = 1'b0;
              if (shift_q[0])
              begin
                // fetch first read byte during the ack clock
                req_d = '{write: 1'b0, addr: ptr_q, data: isrp_pkg::BYTE_RST};
                reqTgl_d = ~reqTgl_q;
              end
            end
            else
              state_d = isrp_pkg::ST_IGNORE;
          end
        isrp_pkg::ST_ADDR_ACK:
          if (sclFall)
          begin
            bitCnt_d = isrp_pkg::BIT_RST;
            if (rwRead_q)
            begin
              state_d = isrp_pkg::ST_RDATA;
              shift_d = rdBuf_q;
              sdaBit_d = rdBuf_q[7];
            end
            else
            begin
              state_d = isrp_pkg::ST_REG;
              drive_d = 1'b0;
            end
          end
        isrp_pkg::ST_REG:
          if (byteDone)
          begin
            ptr_d = shift_q;
            state_d = isrp_pkg::ST_WR_ACK;
            drive_d = 1'b1;
            sdaBit_d = 1'b0;
          end
        isrp_pkg::ST_WR_ACK:
          if (sclFall)
          begin
            state_d = isrp_pkg::ST_WDATA;
            bitCnt_d = isrp_pkg::BIT_RST;
            drive_d = 1'b0;
          end
        isrp_pkg::ST_WDATA:
          if (byteDone)
          begin
            req_d = '{write: 1'b1, addr: ptr_q, data: shift_q};
            reqTgl_d = ~reqTgl_q;
            ptr_d = advance(ptr_q);
            state_d = isrp_pkg::ST_WR_ACK;
            drive_d = 1'b1;
            sdaBit_d = 1'b0;
          end
        isrp_pkg::ST_RDATA:
          if (sclFall)
          begin
            if (bitCnt_q == isrp_pkg::BIT_LAST)
            begin
              state_d = isrp_pkg::ST_RD_ACK;
              drive_d = 1'b0;
            end
            else
            begin
              shift_d = {shift_q[6:0], 1'b0};
              sdaBit_d = shift_q[6];
            end
          end
        isrp_pkg::ST_RD_ACK:
          if (sclRise)
          begin
            if (!sdaF)
            begin
              ptr_d = advance(ptr_q);
              req_d = '{write: 1'b0, addr: advance(ptr_q),
                        data: isrp_pkg::BYTE_RST};
              reqTgl_d = ~reqTgl_q;
            end
            else
              state_d = isrp_pkg::ST_IGNORE;
          end
          else if (sclFall)
          begin
            state_d = isrp_pkg::ST_RDATA;
            bitCnt_d = isrp_pkg::BIT_RST;
            drive_d = 1'b1;
            shift_d = rdBuf_q;
            sdaBit_d = rdBuf_q[7];
          end
        default:
          state_d = isrp_pkg::ST_IDLE;
      endcase
    end
  end

  // link side registers
  always_ff @(posedge linkClk or negedge linkRstn)
  begin
    if (!linkRstn)
    begin
      state_q <= isrp_pkg::ST_IDLE;
      bitCnt_q <= isrp_pkg::BIT_RST;
      shift_q <= isrp_pkg::BYTE_RST;
      ptr_q <= isrp_pkg::PTR_RST;
      drive_q <= 1'b0;
      sdaBit_q <= 1'b1;
      rwRead_q <= 1'b0;
      busy_q <= 1'b0;
      req_q <= isrp_pkg::REQ_RST;
      reqTgl_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      bitCnt_q <= bitCnt_d;
      shift_q <= shift_d;
      ptr_q <= ptr_d;
      drive_q <= drive_d;
      sdaBit_q <= sdaBit_d;
      rwRead_q <= rwRead_d;
      busy_q <= busy_d;
      req_q <= req_d;
      reqTgl_q <= reqTgl_d;
    end
  end

  // ----------------------------------------------------------------
  // SDA pad drive
  // ----------------------------------------------------------------
  logic sdaOe_q;
  logic sdaOut_q;
  logic sdaOeNext;

  // open drain pulls low only; point-to-point drives both levels but
  // only while SCL is low, the keeper holds the line while it is high
  assign sdaOeNext = cfgSync2_q.p2p ? (drive_q & ~sclF) :
                     (drive_q & ~sdaBit_q);

  always_ff @(posedge linkClk or negedge linkRstn)
  begin
    if (!linkRstn)
    begin
      sdaOe_q <= 1'b0;
      sdaOut_q <= 1'b0;
    end
    else
    begin
      sdaOe_q <= sdaOeNext;
      sdaOut_q <= cfgSync2_q.p2p & sdaBit_q;
    end
  end

  assign sdaOe = sdaOe_q;
  assign sdaOut = sdaOut_q;

  // ----------------------------------------------------------------
  // crossing: request toggle to ref_clk, answer toggle back
  // ----------------------------------------------------------------
  logic reqSync1_q;
  logic reqSync2_q;
  logic reqSync3_q;
  logic reqEdge;
  logic busySync1_q;
  logic busySync2_q;
  logic [7:0] regAddr_q;
  logic [7:0] regWrData_q;
  logic regWrStb_q;
  logic regRdStb_q;
  logic [7:0] rdData_q;
  logic ackTgl_q;
  logic ackSync1_q;
  logic ackSync2_q;
  logic ackSync3_q;

  assign reqEdge = reqSync2_q ^ reqSync3_q;

  // register side: one strobe per request, read data captured next cycle
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      reqSync1_q <= 1'b0;
      reqSync2_q <= 1'b0;
      reqSync3_q <= 1'b0;
      busySync1_q <= 1'b0;
      busySync2_q <= 1'b0;
      regAddr_q <= isrp_pkg::PTR_RST;
      regWrData_q <= isrp_pkg::BYTE_RST;
      regWrStb_q <= 1'b0;
      regRdStb_q <= 1'b0;
      rdData_q <= isrp_pkg::BYTE_RST;
      ackTgl_q <= 1'b0;
    end
    else
    begin
      reqSync1_q <= reqTgl_q;
      reqSync2_q <= reqSync1_q;
      reqSync3_q <= reqSync2_q;
      busySync1_q <= busy_q;
      busySync2_q <= busySync1_q;
      regWrStb_q <= reqEdge & req_q.write;
      regRdStb_q <= reqEdge & ~req_q.write;
      if (reqEdge)
      begin
        regAddr_q <= req_q.addr;
        regWrData_q <= req_q.data;
      end
      if (regRdStb_q)
      begin
        rdData_q <= regRdData;
        ackTgl_q <= ~ackTgl_q;
      end
    end
  end

  assign regAddr = regAddr_q;
  assign regWrData = regWrData_q;
  assign regWrStb = regWrStb_q;
  assign regRdStb = regRdStb_q;
  assign busBusy = busySync2_q;

  // read answer taken into the link domain, no SCL stretch to wait for it
  always_ff @(posedge linkClk or negedge linkRstn)
  begin
    if (!linkRstn)
    begin
      ackSync1_q <= 1'b0;
      ackSync2_q <= 1'b0;
      ackSync3_q <= 1'b0;
      rdBuf_q <= isrp_pkg::BYTE_RST;
    end
    else
    begin
      ackSync1_q <= ackTgl_q;
      ackSync2_q <= ackSync1_q;
      ackSync3_q <= ackSync2_q;
      if (ackSync2_q ^ ackSync3_q)
        rdBuf_q <= rdData_q;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence addrByteHit;
    (state_q == isrp_pkg::ST_ADDR) && byteDone && addrMatch;
  endsequence

  sequence ackLowDriven;
    ##[1:2] (sdaOe_q && !sdaOut_q);
  endsequence

  AST_ADDR_ACK: assert property (@(posedge linkClk)
    disable iff (!linkRstn)
    addrByteHit |-> ackLowDriven)
    else $error("address match not acknowledged");

  AST_GENCALL_SILENT: assert property (@(posedge linkClk)
    disable iff (!linkRstn)
    (state_q == isrp_pkg::ST_ADDR) && byteDone &&
    (shift_q[7:1] == isrp_pkg::GENCALL_ADDR) |=>
    (state_q == isrp_pkg::ST_IGNORE) && !drive_q)
    else $error("general call answered");

  AST_DEVID_SILENT: assert property (@(posedge linkClk)
    disable iff (!linkRstn)
    (state_q == isrp_pkg::ST_ADDR) && byteDone &&
    (shift_q[7:1] == isrp_pkg::DEVID_ADDR) |=> !drive_q ##1 !sdaOe_q)
    else $error("device id request answered");

  AST_START: assert property (@(posedge linkClk)
    disable iff (!linkRstn)
    startEv |=> (state_q == isrp_pkg::ST_ADDR) && busy_q &&
    (bitCnt_q == isrp_pkg::BIT_RST) && !drive_q)
    else $error("start not restarting address phase");

  AST_STOP: assert property (@(posedge linkClk) disable iff (!linkRstn)
    stopEv |=> (state_q == isrp_pkg::ST_IDLE) && !busy_q ##1 !sdaOe_q)
    else $error("stop not freeing bus");

  AST_SDA_CHANGE_LOW: assert property (@(posedge linkClk)
    disable iff (!linkRstn)
    $changed(sdaBit_q) |-> !sclF)
    else $error("data bit changed while clock high");

  AST_IGNORE_RELEASED: assert property (@(posedge linkClk)
    disable iff (!linkRstn)
    (state_q == isrp_pkg::ST_IGNORE) [*2] |-> !sdaOe_q)
    else $error("sda driven while not addressed");

  AST_FIFO_WR_HOLD: assert property (@(posedge linkClk)
    disable iff (!linkRstn)
    (state_q == isrp_pkg::ST_WDATA) && byteDone && (ptr_q == FIFO_ADDR)
    |=> $stable(ptr_q) && req_q.write && (req_q.addr == FIFO_ADDR))
    else $error("fifo write address moved");

  AST_WR_ADVANCE: assert property (@(posedge linkClk)
    disable iff (!linkRstn)
    (state_q == isrp_pkg::ST_WDATA) && byteDone && (ptr_q != FIFO_ADDR)
    |=> (ptr_q == $past(ptr_q) + 8'h01) && $changed(reqTgl_q))
    else $error("write address not advanced");

  AST_RD_ADVANCE: assert property (@(posedge linkClk)
    disable iff (!linkRstn)
    (state_q == isrp_pkg::ST_RD_ACK) && sclRise && !sdaF
    |=> (req_q.addr == ptr_q) && !req_q.write && $changed(reqTgl_q))
    else $error("read pointer not requested");

  AST_P2P_HIGH_FREE: assert property (@(posedge linkClk)
    disable iff (!linkRstn)
    cfgSync2_q.p2p && sclF |=> !sdaOe_q)
    else $error("sda driven with clock high on point-to-point link");

  AST_OD_NO_HIGH: assert property (@(posedge linkClk)
    disable iff (!linkRstn)
    !cfgSync2_q.p2p |=> !(sdaOe_q && sdaOut_q))
    else $error("open drain line driven high");

  AST_P2P_ADDR: assert property (@(posedge linkClk)
    disable iff (!linkRstn)
    cfgSync2_q.p2p && !cfgSync2_q.fromNv |-> !myAddr[1])
    else $error("pin address bit not forced low");

  AST_RD_STROBE: assert property (@(posedge ref_clk)
    disable iff (!rstn)
    regRdStb_q |=> !regRdStb_q && (rdData_q == $past(regRdData)))
    else $error("read strobe not single or data not captured");

endmodule

// ---- logic/isrp_pkg.sv ----
// Purpose: shared constants and types of the i2c register port
// Assumes: 7-bit slave addressing, 8-bit register address space
// Notes: link side oversampled by its own clock, register side on ref_clk
package isrp_pkg;

  // ----------------------------------------------------------------
  // addressing
  // ----------------------------------------------------------------
  localparam logic [4:0] ADDR_UPPER = 5'h0a; // fixed upper address bits
  localparam logic [6:0] GENCALL_ADDR = 7'h00; // general call, never matched
  localparam logic [6:0] DEVID_ADDR = 7'h7c; // device id readout, never matched
  localparam logic [3:0] BIT_LAST = 4'h8; // eighth bit of a byte clocked
  localparam logic [3:0] BIT_RST = 4'h0;

  // ----------------------------------------------------------------
  // timing and reset values
  // ----------------------------------------------------------------
  localparam int SPIKE_NS = 50; // spikes shorter than this are dropped
  localparam int LINK_PERIOD_NS = 12; // link sampling clock period
  localparam int FILT_CYC = (SPIKE_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
  localparam logic [2:0] FILT_LAST = 3'(FILT_CYC - 1);
  localparam logic [2:0] FILT_RST = 3'h0;
  localparam logic [1:0] LINE_IDLE = 2'h3; // both lines high when idle
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [7:0] PTR_RST = 8'h00;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_ADDR = 4'b0001,
    ST_ADDR_ACK = 4'b0010,
    ST_REG = 4'b0011,
    ST_WR_ACK = 4'b0100,
    ST_WDATA = 4'b0101,
    ST_RDATA = 4'b0110,
    ST_RD_ACK = 4'b0111,
    ST_IGNORE = 4'b1000
  } isrp_state_e;

  // static configuration straps
  typedef struct packed {
    logic p2p; // point_to_point_i2c_variant selected
    logic fromNv; // low address bits from nonvolatile setting
    logic [1:0] pinBits; // low address bits from pins
    logic [1:0] nvBits; // low address bits from nonvolatile setting
  } isrp_cfg_s;

  // register access passed from link to register side
  typedef struct packed {
    logic write;
    logic [7:0] addr;
    logic [7:0] data;
  } isrp_req_s;

  localparam isrp_req_s REQ_RST = '{write: 1'b0, addr: 8'h00, data: 8'h00};
  localparam isrp_cfg_s CFG_RST = '{p2p: 1'b0, fromNv: 1'b0,
                                    pinBits: 2'h0, nvBits: 2'h0};

endpackage

// ---- tb/isrp_host_model.sv ----
// Purpose: i2c master model driving SCL and SDA, open-drain pull or point-to-point push-pull
// Assumes: pull-up on SDA, 1 MHz fast-mode-plus bit timing
// Notes: data changes a quarter bit into SCL low, sampled mid high
`timescale 1ns/10ps

module isrp_host_model #(
  parameter int QTR_NS = 250
) (
  output logic scl,
  output logic sdaDrv,
  output logic sdaEn,
  input wire logic sda
);
  // ----------------------------------------------------------------
  // idle lines
  // ----------------------------------------------------------------
  // master alone makes the clock, push-pull, in both modes
  initial
  begin
    scl = 1'b1;
    sdaDrv = 1'b1;
    sdaEn = 1'b1;
  end

  // ----------------------------------------------------------------
  // bus conditions
  // ----------------------------------------------------------------
  // start or repeated start from idle or SCL low
  task automatic start();
    sdaEn = 1'b1;
    sdaDrv = 1'b1;
    #QTR_NS scl = 1'b1;
    #QTR_NS sdaDrv = 1'b0;
    #QTR_NS scl = 1'b0;
    #QTR_NS;
  endtask

  // stop: SDA rises while SCL high
  task automatic stop();
    sdaEn = 1'b1;
    sdaDrv = 1'b0;
    #QTR_NS scl = 1'b1;
    #QTR_NS sdaDrv = 1'b1;
    #(2 * QTR_NS);
  endtask

  // one clock, SDA steady through SCL high
  task automatic clockBit(input logic b, output logic got);
    sdaDrv = b;
    #QTR_NS scl = 1'b1;
    #QTR_NS got = sda;
    #QTR_NS scl = 1'b0;
    #QTR_NS;
  endtask

  // byte out msb first, released SDA on the ack clock
  task automatic writeByte(input logic [7:0] b, output logic ack);
    logic got;
    sdaEn = 1'b1;
    for (int i = 7; i >= 0; i--)
      clockBit(b[i], got);
    sdaEn = 1'b0; // listen on the ack clock
    clockBit(1'b1, got);
    ack = ~got;
  endtask

  // byte in; no ack on the last one ends the read
  task automatic readByte(input logic ack, output logic [7:0] b);
    logic got;
    sdaEn = 1'b0;
    for (int i = 7; i >= 0; i--)
      clockBit(1'b1, b[i]);
    sdaEn = 1'b1;
    clockBit(~ack, got);
  endtask
endmodule

// ---- tb/i2c_slave_register_port_test.sv ----
// Purpose: self-checking bench of the i2c register port slave
// Assumes: slave address low bits from pins = 2'b10, FIFO at 8'h05
// Notes: register file modelled here; FIFO returns a pop counter
`timescale 1ns/10ps

module i2c_slave_register_port_test;
  logic ref_clk = 1'b0;
  logic linkClk = 1'b0;
  logic rstn = 1'b0;
  logic scl, sdaDrv, sdaEn, sdaOut, sdaOe, regWrStb, regRdStb, busBusy;
  logic [7:0] regAddr, regWrData, regRdData;
  logic [7:0] fifoCnt = 8'h00;
  logic [15:0] wrLog[$];
  wire logic sda;
  int mismatches = 0;
  int numChecks = 0;
  logic [7:0] devW = 8'h54; // address byte with write bit
  logic keep = 1'b1;
  isrp_pkg::isrp_cfg_s cfg = '{p2p: 1'b0, fromNv: 1'b0,
                              pinBits: 2'h2, nvBits: 2'h1};

  // open drain with pull-up; point-to-point keeper holds
  assign sda = !cfg.p2p ? (sdaDrv & ~(sdaOe & ~sdaOut)) :
               sdaOe ? sdaOut : sdaEn ? sdaDrv : keep;
  always @(sda) keep = sda;
  // register contents; FIFO place answers the pop count
  assign regRdData = (regAddr == 8'h05) ? fifoCnt : regAddr ^ 8'h5a;

  // ----------------------------------------------------------------
  // clocks and register-side model
  // ----------------------------------------------------------------
  initial
  begin
    forever #12.5 ref_clk = ~ref_clk;
  end
  initial
  begin
    #3;
    forever #6 linkClk = ~linkClk;
  end
  always @(posedge ref_clk)
  begin
    if (regWrStb === 1'b1)
      wrLog.push_back({regAddr, regWrData});
    if (regRdStb === 1'b1 && regAddr == 8'h05)
      fifoCnt <= fifoCnt + 8'h01;
  end

  isrp_slave #(.FIFO_ADDR(8'h05)) isrp_slave_inst (
    .ref_clk(ref_clk), .rstn(rstn), .linkClk(linkClk), .sclIn(scl),
    .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe), .cfgIn(cfg),
    .regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb),
    .regRdStb(regRdStb), .regRdData(regRdData), .busBusy(busBusy)
  );
  isrp_host_model isrp_host_model_inst (
    .scl(scl), .sdaDrv(sdaDrv), .sdaEn(sdaEn), .sda(sda)
  );

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    numChecks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    if (mismatches == 0 && numChecks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // address, register and two data bytes, acks checked on the first three
  task automatic wrFrame(input logic [7:0] regA, input logic [15:0] d);
    logic ack;
    isrp_host_model_inst.start();
    isrp_host_model_inst.writeByte(devW, ack);
    check(16'(ack), 16'h0001);
    isrp_host_model_inst.writeByte(regA, ack);
    check(16'(ack), 16'h0001);
    isrp_host_model_inst.writeByte(d[15:8], ack);
    check(16'(ack), 16'h0001);
    isrp_host_model_inst.writeByte(d[7:0], ack);
    check(16'(busBusy), 16'h0001);
    isrp_host_model_inst.stop();
    repeat (10) @(posedge ref_clk);
    check(16'(busBusy), 16'h0000);
  endtask

  // register-only write, repeated start, two reads, last one refused
  task automatic rdFrame(input logic [7:0] regA, output logic [15:0] d);
    logic ack;
    isrp_host_model_inst.start();
    isrp_host_model_inst.writeByte(devW, ack);
    isrp_host_model_inst.writeByte(regA, ack);
    isrp_host_model_inst.start();
    isrp_host_model_inst.writeByte(devW | 8'h01, ack);
    check(16'(ack), 16'h0001);
    isrp_host_model_inst.readByte(1'b1, d[15:8]);
    isrp_host_model_inst.readByte(1'b0, d[7:0]);
    isrp_host_model_inst.stop();
    repeat (10) @(posedge ref_clk);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic testWrites();
    wrLog.delete();
    wrFrame(8'h10, 16'ha53c);
    wrFrame(8'h05, 16'h1122);
    check(16'(wrLog.size()), 16'h0004);
    check(wrLog[0], 16'h10a5);
    check(wrLog[1], 16'h113c);
    check(wrLog[2], 16'h0511);
    check(wrLog[3], 16'h0522);
  endtask

  task automatic testReads();
    logic [15:0] d;
    logic [7:0] c;
    rdFrame(8'h20, d);
    check(d, 16'h7a7b);
    c = fifoCnt;
    rdFrame(8'h05, d);
    check(d, {c, c + 8'h01});
    check(16'(fifoCnt), 16'(c + 8'h02));
  endtask

  task automatic testForeign();
    logic [7:0] devs[3] = '{8'h00, 8'hf8, 8'h56};
    logic ack;
    wrLog.delete();
    foreach (devs[i])
    begin
      isrp_host_model_inst.start();
      isrp_host_model_inst.writeByte(devs[i], ack);
      check(16'(ack), 16'h0000);
      isrp_host_model_inst.writeByte(8'h10, ack);
      check(16'(ack), 16'h0000);
      isrp_host_model_inst.stop();
    end
    repeat (10) @(posedge ref_clk);
    check(16'(wrLog.size()), 16'h0000);
  endtask

  // point-to-point: pin address with forced bit, then nonvolatile one
  task automatic testP2p();
    logic ack;
    logic [15:0] d;
    @(posedge ref_clk);
    #1 cfg = '{p2p: 1'b1, fromNv: 1'b0, pinBits: 2'h3, nvBits: 2'h3};
    repeat (10) @(posedge ref_clk);
    isrp_host_model_inst.start();
    isrp_host_model_inst.writeByte(8'h57, ack);
    check(16'(ack), 16'h0000);
    isrp_host_model_inst.stop();
    devW = 8'h52;
    wrLog.delete();
    wrFrame(8'h30, 16'h9669);
    check(16'(wrLog.size()), 16'h0002);
    check(wrLog[0], 16'h3096);
    check(wrLog[1], 16'h3169);
    @(posedge ref_clk);
    #1 cfg.fromNv = 1'b1;
    devW = 8'h56;
    repeat (10) @(posedge ref_clk);
    rdFrame(8'h40, d);
    check(d, 16'h1a1b);
  endtask

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    repeat (8) @(posedge ref_clk);
    #1 rstn = 1'b1;
    repeat (20) @(posedge ref_clk);
    testWrites();
    testReads();
    testForeign();
    testP2p();
    give_verdict();
  end
  initial
  begin
    #1000000;
    mismatches++;
    give_verdict();
  end
endmodule
